/* hdl/ssp_consts.vh */
// constants for the sync serial port: register map, fields, resets, timing
// Operation
// - port comes up disabled until configured
// - master drives clock, slave follows one
// - spi, frame-pulse or command-response framing as master, spi select framing only as slave
// - separate tx and rx fifos, 8 words of 16 bits
// - frame size four to sixteen bits
// - bit rate from prescale and rate divider
// - enabled port shifts out and captures data
// - tx, rx service and overrun, each maskable
// - loopback feeds transmit back to receive internally
// - registers at fixed base plus offset
// - data read pops rx, write pushes tx
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// base address bits 31:8 and register offsets
`define SSP_BASE_HI     24'h400022
`define SSP_OFS_FFC     8'h00
`define SSP_OFS_OPC     8'h04
`define SSP_OFS_DATA    8'h08
`define SSP_OFS_STAT    8'h0C
`define SSP_OFS_CPS     8'h10
`define SSP_OFS_IMSC    8'h14
`define SSP_OFS_RIS     8'h18
`define SSP_OFS_MIS     8'h1C
`define SSP_OFS_ICR     8'h20
`define SSP_OFS_DMA     8'h24

// frame_format_control fields
`define SSP_F_SCR       15:8
`define SSP_F_SPH       7
`define SSP_F_SPO       6
`define SSP_F_FRF       5:4
`define SSP_F_DSS       3:0

// operation_control fields
`define SSP_F_LBM       0
`define SSP_F_EN        1
`define SSP_F_SLV       2
`define SSP_F_SOD       3

// interrupt bit positions
`define SSP_I_ROR       0
`define SSP_I_RT        1
`define SSP_I_RX        2
`define SSP_I_TX        3

// dma_request_control bits
`define SSP_D_RX        0
`define SSP_D_TX        1

// reset values
`define SSP_RST_FFC     16'h0000
`define SSP_RST_OPC     4'h0
`define SSP_RST_CPS     8'h00
`define SSP_RST_IMSC    4'h0
`define SSP_RST_DMA     2'h0

// frame formats
`define SSP_FMT_SPI     2'h0
`define SSP_FMT_SSI     2'h1
`define SSP_FMT_CR      2'h2

// timing and sizes
`define SSP_CR_CMD_BITS 5'h08
`define SSP_DSS_MIN     4'h3
`define SSP_CPS_MIN     8'h02
`define SSP_RT_LAST     7'h3F

`endif

/* hdl/ssp_fifo.v */
// small fifo memory with registered read data
`timescale 1ns/1ps

module ssp_fifo #(
	parameter WIDTH  = 16,
	parameter DEPTH  = 8,
	parameter ADDR_W = 3
) (
	input  wire              sys_clk,
	input  wire              rst,
	input  wire              push,
	input  wire [WIDTH-1:0]  wdata,
	input  wire              pop,
	output reg  [WIDTH-1:0]  rdata,
	output reg  [ADDR_W:0]   count,
	output wire              full,
	output wire              empty
);

localparam [ADDR_W:0]   FULL_N = DEPTH[ADDR_W:0];
localparam [ADDR_W:0]   C_ONE  = {{ADDR_W{1'b0}}, 1'b1};
localparam [ADDR_W-1:0] P_ONE  = {{(ADDR_W-1){1'b0}}, 1'b1};

reg  [WIDTH-1:0]  mem [0:DEPTH-1];
reg  [ADDR_W-1:0] wr_q;
reg  [ADDR_W-1:0] rd_q;
wire              do_push;
wire              do_pop;

assign full    = (count == FULL_N);
assign empty   = (count == {(ADDR_W+1){1'b0}});
assign do_push = push && !full;
assign do_pop  = pop && !empty;

// storage has no reset; contents are only read behind count
always @(posedge sys_clk)
begin
	if (do_push)
		mem[wr_q] <= wdata;
end

always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		wr_q  <= {ADDR_W{1'b0}};
		rd_q  <= {ADDR_W{1'b0}};
		rdata <= {WIDTH{1'b0}};
		count <= {(ADDR_W+1){1'b0}};
	end
	else
	begin
		if (do_push)
			wr_q <= wr_q + P_ONE;
		if (do_pop)
		begin
			rd_q  <= rd_q + P_ONE;
			rdata <= mem[rd_q];
		end
		if (do_push && !do_pop)
			count <= count + C_ONE;
		else if (do_pop && !do_push)
			count <= count - C_ONE;
	end
end

endmodule // ssp_fifo

/* hdl/ssp_port.v */
// sync serial port: register slave, bit-rate divider, master/slave shift engine
`timescale 1ns/1ps
`include "ssp_consts.vh"

module ssp_port #(
	parameter DEPTH  = 8,
	parameter ADDR_W = 3
) (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        reg_sel,
	input  wire        reg_write,
	input  wire [31:0] reg_addr,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata,
	output reg         reg_rvalid,
	output reg         port_intr,
	output reg         tx_dma_req,
	output reg         rx_dma_req,
	input  wire        serial_clock_in,
	output reg         serial_clock_out,
	output reg         serial_clock_oe,
	input  wire        frame_in,
	output reg         frame_out,
	output reg         frame_oe,
	output reg         serial_transmit_line,
	output reg         serial_transmit_oe,
	input  wire        serial_receive_line
);

localparam [1:0]      M_IDLE = 2'h0;
localparam [1:0]      M_LOAD = 2'h1;
localparam [1:0]      M_RUN  = 2'h2;
localparam [1:0]      M_GAP  = 2'h3;
localparam [ADDR_W:0] HALF   = DEPTH[ADDR_W+1:1];

function [15:0] align_word;
	input [15:0] w;
	input [4:0]  n;
	begin
		align_word = w << (5'h10 - n);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers and decode

reg  [15:0]     ffc_q;
reg  [3:0]      opc_q;
reg  [7:0]      cps_q;
reg  [3:0]      imsc_q;
reg  [1:0]      dma_q;
reg             ror_q;
reg             rt_q;
reg  [6:0]      rt_cnt_q;
reg             rd_pend_q;
reg  [7:0]      rd_ofs_q;
reg             rd_pop_q;
reg  [15:0]     rd_mux;

reg  [1:0]      st_q;
reg             half_q;
reg             pre_q;
reg  [4:0]      cnt_q;
reg  [15:0]     tx_sh_q;
reg  [15:0]     rx_sh_q;
reg  [15:0]     rx_word_q;
reg             rx_push_q;
reg             need_q;
reg             load_q;
reg  [6:0]      pre_cnt_q;
reg  [7:0]      scr_cnt_q;
reg             sck_s1_q;
reg             sck_s2_q;
reg             sck_s3_q;
reg             cs_s1_q;
reg             cs_s2_q;
reg             rx_s1_q;
reg             rx_s2_q;

wire [15:0]     tx_dout;
wire [15:0]     rx_dout;
wire            tx_full;
wire            tx_empty;
wire            rx_full;
wire            rx_empty;
wire [ADDR_W:0] tx_count;
wire [ADDR_W:0] rx_count;

wire        bus_hit  = reg_sel && (reg_addr[31:8] == `SSP_BASE_HI);
wire [7:0]  ofs      = reg_addr[7:0];
wire        bus_wr   = bus_hit && reg_write;
wire        bus_rd   = bus_hit && !reg_write;
wire        tx_push  = bus_wr && (ofs == `SSP_OFS_DATA);
wire        rx_pop   = bus_rd && (ofs == `SSP_OFS_DATA) && !rx_empty;
wire        icr_wr   = bus_wr && (ofs == `SSP_OFS_ICR);

wire        en       = opc_q[`SSP_F_EN];
wire        slave    = opc_q[`SSP_F_SLV];
wire [1:0]  fmt      = ffc_q[`SSP_F_FRF];
wire        sph      = ffc_q[`SSP_F_SPH];
wire        spo      = ffc_q[`SSP_F_SPO];
wire [3:0]  dss      = (ffc_q[`SSP_F_DSS] < `SSP_DSS_MIN) ? `SSP_DSS_MIN : ffc_q[`SSP_F_DSS];
wire [4:0]  nbits    = {1'b0, dss} + 5'h01;
wire        is_cr    = (fmt == `SSP_FMT_CR);
wire [4:0]  total    = is_cr ? nbits + `SSP_CR_CMD_BITS : nbits;
wire        cpol     = (fmt == `SSP_FMT_SPI) && spo;
wire        cpha     = (fmt == `SSP_FMT_SPI) ? sph : (fmt == `SSP_FMT_SSI);
wire        fidle    = (fmt != `SSP_FMT_SSI);
wire [15:0] tx_new   = (is_cr && !slave) ? {tx_dout[7:0], 8'h00} : align_word(tx_dout, nbits);
wire        rx_bit   = opc_q[`SSP_F_LBM] ? serial_transmit_line : rx_s2_q;
wire [15:0] rx_next  = {rx_sh_q[14:0], rx_bit};
wire [15:0] rx_mask  = ~(16'hFFFF << nbits);
wire        rx_wr    = rx_push_q && !rx_full;
wire        ror_set  = rx_push_q && rx_full;

wire        m_pop    = en && !slave && (st_q == M_IDLE) && !tx_empty;
wire        s_pop    = en && slave && need_q && !load_q && !tx_empty;
wire        tx_pop   = m_pop || s_pop;

wire        sck_rise = sck_s2_q && !sck_s3_q;
wire        sck_fall = !sck_s2_q && sck_s3_q;
wire        s_sample = !cs_s2_q && ((spo ^ sph) ? sck_fall : sck_rise);
wire        s_shift  = !cs_s2_q && ((spo ^ sph) ? sck_rise : sck_fall);

wire [7:0]  cps_e    = (cps_q < `SSP_CPS_MIN) ? `SSP_CPS_MIN : cps_q;
wire [6:0]  pre_top  = cps_e[7:1] - 7'h01;
wire        pre_tick = (pre_cnt_q == pre_top);
wire        edge_tk  = pre_tick && (scr_cnt_q == ffc_q[`SSP_F_SCR]);

wire        bsy      = (st_q != M_IDLE) || !tx_empty || (slave && en && !cs_s2_q);
wire [4:0]  status   = {bsy, rx_full, !rx_empty, !tx_full, tx_empty};
wire [3:0]  ris      = {(tx_count <= HALF), (rx_count >= HALF), rt_q, ror_q};
wire [3:0]  mis      = ris & imsc_q;
wire        rx_act   = rx_push_q || rx_pop;
wire        rt_hit   = en && edge_tk && !rx_empty && !rx_act && (rt_cnt_q == `SSP_RT_LAST);

ssp_fifo #(.WIDTH(16), .DEPTH(DEPTH), .ADDR_W(ADDR_W)) u_tx_fifo (
	.sys_clk (sys_clk),
	.rst     (rst),
	.push    (tx_push),
	.wdata   (reg_wdata),
	.pop     (tx_pop),
	.rdata   (tx_dout),
	.count   (tx_count),
	.full    (tx_full),
	.empty   (tx_empty)
);

ssp_fifo #(.WIDTH(16), .DEPTH(DEPTH), .ADDR_W(ADDR_W)) u_rx_fifo (
	.sys_clk (sys_clk),
	.rst     (rst),
	.push    (rx_wr),
	.wdata   (rx_word_q),
	.pop     (rx_pop),
	.rdata   (rx_dout),
	.count   (rx_count),
	.full    (rx_full),
	.empty   (rx_empty)
);

always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		ffc_q  <= `SSP_RST_FFC;
		opc_q  <= `SSP_RST_OPC;
		cps_q  <= `SSP_RST_CPS;
		imsc_q <= `SSP_RST_IMSC;
		dma_q  <= `SSP_RST_DMA;
	end
	else if (bus_wr)
	begin
		case (ofs)
		`SSP_OFS_FFC:  ffc_q  <= reg_wdata;
		`SSP_OFS_OPC:  opc_q  <= reg_wdata[3:0];
		`SSP_OFS_CPS:  cps_q  <= {reg_wdata[7:1], 1'b0};
		`SSP_OFS_IMSC: imsc_q <= reg_wdata[3:0];
		`SSP_OFS_DMA:  dma_q  <= reg_wdata[1:0];
		default:       ffc_q  <= ffc_q;
		endcase
	end
end

// latched flags: a new event beats a clear in the same cycle
always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		ror_q    <= 1'b0;
		rt_q     <= 1'b0;
		rt_cnt_q <= 7'h00;
	end
	else
	begin
		if (ror_set)
			ror_q <= 1'b1;
		else if (icr_wr && reg_wdata[`SSP_I_ROR])
			ror_q <= 1'b0;
		if (rt_hit)
			rt_q <= 1'b1;
		else if (icr_wr && reg_wdata[`SSP_I_RT])
			rt_q <= 1'b0;
		if (!en || rx_empty || rx_act)
			rt_cnt_q <= 7'h00;
		else if (edge_tk && (rt_cnt_q != `SSP_RT_LAST))
			rt_cnt_q <= rt_cnt_q + 7'h01;
	end
end

always @*
begin
	case (rd_ofs_q)
	`SSP_OFS_FFC:  rd_mux = ffc_q;
	`SSP_OFS_OPC:  rd_mux = {12'h000, opc_q};
	`SSP_OFS_DATA: rd_mux = rd_pop_q ? rx_dout : 16'h0000;
	`SSP_OFS_STAT: rd_mux = {11'h0, status};
	`SSP_OFS_CPS:  rd_mux = {8'h00, cps_q};
	`SSP_OFS_IMSC: rd_mux = {12'h000, imsc_q};
	`SSP_OFS_RIS:  rd_mux = {12'h000, ris};
	`SSP_OFS_MIS:  rd_mux = {12'h000, mis};
	`SSP_OFS_DMA:  rd_mux = {14'h0, dma_q};
	default:       rd_mux = 16'h0000;
	endcase
end

// reads answer two edges after the request, waiting on the fifo's read register
always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		rd_pend_q  <= 1'b0;
		rd_ofs_q   <= 8'h00;
		rd_pop_q   <= 1'b0;
		reg_rvalid <= 1'b0;
		reg_rdata  <= 16'h0000;
		port_intr  <= 1'b0;
		tx_dma_req <= 1'b0;
		rx_dma_req <= 1'b0;
	end
	else
	begin
		rd_pend_q  <= bus_rd;
		rd_ofs_q   <= ofs;
		rd_pop_q   <= rx_pop;
		reg_rvalid <= rd_pend_q;
		reg_rdata  <= rd_pend_q ? rd_mux : 16'h0000;
		port_intr  <= |mis;
		tx_dma_req <= dma_q[`SSP_D_TX] && !tx_full;
		rx_dma_req <= dma_q[`SSP_D_RX] && !rx_empty;
	end
end

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers, divider, pin enables

always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		sck_s1_q           <= 1'b0;
		sck_s2_q           <= 1'b0;
		sck_s3_q           <= 1'b0;
		cs_s1_q            <= 1'b1;
		cs_s2_q            <= 1'b1;
		rx_s1_q            <= 1'b0;
		rx_s2_q            <= 1'b0;
		pre_cnt_q          <= 7'h00;
		scr_cnt_q          <= 8'h00;
		serial_clock_oe    <= 1'b0;
		frame_oe           <= 1'b0;
		serial_transmit_oe <= 1'b0;
	end
	else
	begin
		sck_s1_q           <= serial_clock_in;
		sck_s2_q           <= sck_s1_q;
		sck_s3_q           <= sck_s2_q;
		cs_s1_q            <= frame_in;
		cs_s2_q            <= cs_s1_q;
		rx_s1_q            <= serial_receive_line;
		rx_s2_q            <= rx_s1_q;
		serial_clock_oe    <= en && !slave;
		frame_oe           <= en && !slave;
		serial_transmit_oe <= en && (!slave || (!opc_q[`SSP_F_SOD] && !cs_s2_q));
		// restart at each word so the first half period is full length
		if (!en || (st_q == M_LOAD))
		begin
			pre_cnt_q <= 7'h00;
			scr_cnt_q <= 8'h00;
		end
		else if (pre_tick)
		begin
			pre_cnt_q <= 7'h00;
			scr_cnt_q <= edge_tk ? 8'h00 : scr_cnt_q + 8'h01;
		end
		else
			pre_cnt_q <= pre_cnt_q + 7'h01;
	end
end

////////////////////////////////////////////////////////////////////////////////
// shift engine

always @(posedge sys_clk or posedge rst)
begin
	if (rst)
	begin
		st_q                 <= M_IDLE;
		half_q               <= 1'b0;
		pre_q                <= 1'b0;
		cnt_q                <= 5'h00;
		tx_sh_q              <= 16'h0000;
		rx_sh_q              <= 16'h0000;
		rx_word_q            <= 16'h0000;
		rx_push_q            <= 1'b0;
		need_q               <= 1'b1;
		load_q               <= 1'b0;
		serial_clock_out     <= 1'b0;
		frame_out            <= 1'b1;
		serial_transmit_line <= 1'b0;
	end
	else
	begin
		rx_push_q <= 1'b0;
		load_q    <= s_pop;
		if (!en)
		begin
			st_q             <= M_IDLE;
			need_q           <= 1'b1;
			cnt_q            <= nbits;
			serial_clock_out <= cpol;
			frame_out        <= fidle;
		end
		else if (!slave)
		begin
			case (st_q)
			M_IDLE:
			begin
				serial_clock_out <= cpol;
				frame_out        <= fidle;
				if (!tx_empty)
					st_q <= M_LOAD;
			end
			M_LOAD:
			begin
				cnt_q     <= total;
				half_q    <= 1'b0;
				pre_q     <= (fmt == `SSP_FMT_SSI);
				frame_out <= !fidle;
				if (cpha)
					tx_sh_q <= tx_new;
				else
				begin
					serial_transmit_line <= tx_new[15];
					tx_sh_q              <= {tx_new[14:0], 1'b0};
				end
				st_q <= M_RUN;
			end
			M_RUN:
			begin
				if (edge_tk)
				begin
					serial_clock_out <= !serial_clock_out;
					half_q           <= !half_q;
					if (pre_q)
					begin
						if (half_q)
						begin
							pre_q     <= 1'b0;
							frame_out <= 1'b0;
						end
					end
					else if (!half_q)
					begin
						if (cpha)
						begin
							serial_transmit_line <= tx_sh_q[15];
							tx_sh_q              <= {tx_sh_q[14:0], 1'b0};
						end
						else
							rx_sh_q <= rx_next;
					end
					else
					begin
						cnt_q <= cnt_q - 5'h01;
						if (cpha)
							rx_sh_q <= rx_next;
						else if (cnt_q != 5'h01)
						begin
							serial_transmit_line <= tx_sh_q[15];
							tx_sh_q              <= {tx_sh_q[14:0], 1'b0};
						end
						if (cnt_q == 5'h01)
						begin
							rx_word_q <= (cpha ? rx_next : rx_sh_q) & rx_mask;
							rx_push_q <= 1'b1;
							frame_out <= fidle;
							st_q      <= M_GAP;
						end
					end
				end
			end
			M_GAP:
			begin
				if (edge_tk)
					st_q <= M_IDLE;
			end
			default:
				st_q <= M_IDLE;
			endcase
		end
		else
		begin
			st_q             <= M_IDLE;
			serial_clock_out <= cpol;
			frame_out        <= fidle;
			if (s_pop)
				need_q <= 1'b0;
			if (load_q)
			begin
				if (sph)
					tx_sh_q <= tx_new;
				else
				begin
					serial_transmit_line <= tx_new[15];
					tx_sh_q              <= {tx_new[14:0], 1'b0};
				end
			end
			else if (cs_s2_q)
				cnt_q <= nbits;
			else if (s_shift)
			begin
				serial_transmit_line <= tx_sh_q[15];
				tx_sh_q              <= {tx_sh_q[14:0], 1'b0};
			end
			else if (s_sample)
			begin
				rx_sh_q <= rx_next;
				cnt_q   <= cnt_q - 5'h01;
				if (cnt_q == 5'h01)
				begin
					rx_word_q <= rx_next & rx_mask;
					rx_push_q <= 1'b1;
					cnt_q     <= nbits;
					need_q    <= 1'b1;
				end
			end
		end
	end
end

endmodule // ssp_port

/* verification/ssp_peer.sv */
// mode-0 serial peer on the far side of the master link
`timescale 1ns/1ps

module ssp_peer (
	input  wire        sclk,
	input  wire        sel_n,
	input  wire        mosi,
	input  wire [15:0] tx_word,
	input  wire [4:0]  nbits,
	output reg         miso,
	output reg  [15:0] rx_word
);
	integer cnt;

	initial
	begin
		miso    = 1'b0;
		rx_word = 16'h0000;
		cnt     = 0;
	end
	// first bit ready as soon as selected
	always @(negedge sel_n)
	begin
		cnt     = 0;
		rx_word = 16'h0000;
		miso    = tx_word[nbits-1];
	end
	always @(posedge sclk)
		if (!sel_n)
		begin
			rx_word = {rx_word[14:0], mosi};
			cnt     = cnt + 1;
		end
	always @(negedge sclk)
		if (!sel_n && cnt < nbits)
			miso = tx_word[nbits-1-cnt];
	// released line must not keep the last bit
	always @(posedge sel_n)
		miso = ~miso;
endmodule // ssp_peer

/* verification/ssp_port_properties.sv */
// concurrent checks on the sync serial port ports
`timescale 1ns/1ps
`include "ssp_consts.vh"

module ssp_port_properties (
	input wire        sys_clk,
	input wire        rst,
	input wire        reg_sel,
	input wire        reg_write,
	input wire [31:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata,
	input wire        reg_rvalid,
	input wire        port_intr,
	input wire        tx_dma_req,
	input wire        rx_dma_req,
	input wire        serial_clock_oe,
	input wire        frame_oe,
	input wire        serial_transmit_oe
);
	reg  [3:0] opc_q;
	reg  [3:0] mask_q;
	reg  [1:0] dma_q;
	wire       hit    = reg_sel && (reg_addr[31:8] == `SSP_BASE_HI);
	wire       rd_hit = hit && !reg_write;
	wire       wr_hit = hit && reg_write;
	wire       dis    = !opc_q[`SSP_F_EN];
	wire       slv    = opc_q[`SSP_F_EN] && opc_q[`SSP_F_SLV];
	wire       mst    = opc_q[`SSP_F_EN] && !opc_q[`SSP_F_SLV];
	wire       mask_0 = (mask_q == 4'h0);
	wire       dtx    = !dma_q[`SSP_D_TX];
	wire       drx    = !dma_q[`SSP_D_RX];

	////////////////////////////////////////////////////////////////
	// shadow copies of control writes
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			opc_q  <= 4'h0;
			mask_q <= 4'h0;
			dma_q  <= 2'h0;
		end
		else if (wr_hit)
		begin
			if (reg_addr[7:0] == `SSP_OFS_OPC)
				opc_q <= reg_wdata[3:0];
			if (reg_addr[7:0] == `SSP_OFS_IMSC)
				mask_q <= reg_wdata[3:0];
			if (reg_addr[7:0] == `SSP_OFS_DMA)
				dma_q <= reg_wdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_read_answer;
		rd_hit |-> ##2 reg_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	property p_no_stray;
		reg_rvalid |-> $past(rd_hit, 2);
	endproperty
	a_no_stray: assert property (p_no_stray) else $error("answer without read");
	property p_rdata_zero;
		!reg_rvalid |-> (reg_rdata == 16'h0000);
	endproperty
	a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside answer");
	property p_disabled;
		dis && $past(dis) |-> !serial_clock_oe && !frame_oe && !serial_transmit_oe;
	endproperty
	a_disabled: assert property (p_disabled) else $error("pins driven while disabled");
	property p_slave_quiet;
		slv && $past(slv) |-> !serial_clock_oe && !frame_oe;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives clock");
	property p_master_drive;
		mst && $past(mst) |-> serial_clock_oe && frame_oe && serial_transmit_oe;
	endproperty
	a_master_drive: assert property (p_master_drive) else $error("master not driving");
	property p_mask_off;
		mask_0 && $past(mask_0) && $past(mask_0, 2) |-> !port_intr;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("interrupt with all masked");
	property p_dtx_off;
		dtx && $past(dtx) |-> !tx_dma_req;
	endproperty
	a_dtx_off: assert property (p_dtx_off) else $error("tx request while off");
	property p_drx_off;
		drx && $past(drx) |-> !rx_dma_req;
	endproperty
	a_drx_off: assert property (p_drx_off) else $error("rx request while off");
endmodule // ssp_port_properties

/* verification/ssp_port_tb.sv */
// self-checking bench for the sync serial port
`timescale 1ns/1ps
`include "ssp_consts.vh"

module ssp_port_tb;
	localparam [79:0]  RST_OFS = 80'h0004_0C10_1418_1C20_2430;
	localparam [159:0] RST_VAL = 160'h0000_0000_0003_0000_0000_0008_0000_0000_0000_0000;
	reg         sys_clk, rst, reg_sel, reg_write, s_clk, s_sel_n;
	reg  [31:0] reg_addr;
	reg  [15:0] reg_wdata, peer_word, v, m;
	reg  [4:0]  peer_bits;
	wire [15:0] reg_rdata, peer_rx;
	wire        reg_rvalid, port_intr, tx_dma_req, rx_dma_req, sck, sck_oe, fr, fr_oe, txd, tx_oe, rxd;
	integer     num_errors, checks_done, i;

	ssp_port i_dut (.sys_clk(sys_clk), .rst(rst), .reg_sel(reg_sel), .reg_write(reg_write),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.port_intr(port_intr), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req),
		.serial_clock_in(s_clk), .serial_clock_out(sck), .serial_clock_oe(sck_oe),
		.frame_in(s_sel_n), .frame_out(fr), .frame_oe(fr_oe), .serial_transmit_line(txd),
		.serial_transmit_oe(tx_oe),
		.serial_receive_line(rxd));
	ssp_peer i_peer (.sclk(sck), .sel_n(fr), .mosi(txd), .tx_word(peer_word), .nbits(peer_bits),
		.miso(rxd), .rx_word(peer_rx));

	always #10 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////
	task chk(input string what, input [15:0] seen, input [15:0] exp);
	begin
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task wr(input [7:0] ofs, input [15:0] d);
	begin
		@(posedge sys_clk);
		reg_sel   <= 1'b1;
		reg_write <= 1'b1;
		reg_addr  <= {`SSP_BASE_HI, ofs};
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_sel   <= 1'b0;
	end
	endtask
	task rd(input [7:0] ofs, output [15:0] d);
		integer n;
	begin
		@(posedge sys_clk);
		reg_sel   <= 1'b1;
		reg_write <= 1'b0;
		reg_addr  <= {`SSP_BASE_HI, ofs};
		@(posedge sys_clk);
		reg_sel   <= 1'b0;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 4)
		begin
			@(posedge sys_clk);
			#1;
			n = n + 1;
		end
		d = reg_rdata;
	end
	endtask
	task poll(input string what, input [7:0] ofs, input [15:0] msk, input [15:0] want);
		integer n;
	begin
		n = 0;
		rd(ofs, v);
		while ((v & msk) !== want && n < 3000)
		begin
			rd(ofs, v);
			n = n + 1;
		end
		chk(what, v & msk, want);
	end
	endtask
	task complete_run;
	begin
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (90000) @(posedge sys_clk);
		num_errors = num_errors + 1;
		complete_run;
	end

	initial
	begin
		sys_clk = 1'b0;
		rst = 1'b1;
		reg_sel = 1'b0;
		reg_write = 1'b0;
		reg_addr = 32'h0000_0000;
		reg_wdata = 16'h0000;
		s_clk = 1'b0;
		s_sel_n = 1'b1;
		peer_word = 16'hC3A5;
		peer_bits = 5'h10;
		num_errors = 0;
		checks_done = 0;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		for (i = 0; i < 10; i = i + 1)
		begin
			rd(RST_OFS[79-8*i -: 8], v);
			chk("reset value", v, RST_VAL[159-16*i -: 16]);
		end
		chk("clock drive", {15'h0, sck_oe}, 16'h0000);
		wr(`SSP_OFS_CPS, 16'h00FF);
		rd(`SSP_OFS_CPS, v);
		chk("prescale", v, 16'h00FE);
		wr(`SSP_OFS_CPS, 16'h0002);
		wr(`SSP_OFS_FFC, 16'h0007);
		$display("test reset done");
		// preload while disabled, ninth word dropped
		for (i = 0; i < 9; i = i + 1)
			wr(`SSP_OFS_DATA, {8'hA5, 4'h3, i[3:0]});
		rd(`SSP_OFS_STAT, v);
		chk("full status", v, 16'h0010);
		rd(`SSP_OFS_RIS, v);
		chk("raw when full", v, 16'h0000);
		wr(`SSP_OFS_OPC, 16'h0003);
		poll("loop status", `SSP_OFS_STAT, 16'h001F, 16'h000F);
		rd(`SSP_OFS_RIS, v);
		chk("fifo flags", v & 16'h000C, 16'h000C);
		wr(`SSP_OFS_DATA, 16'h0077);
		poll("overrun", `SSP_OFS_RIS, 16'h0001, 16'h0001);
		wr(`SSP_OFS_IMSC, 16'h0001);
		rd(`SSP_OFS_MIS, v);
		chk("masked", v, 16'h0001);
		chk("intr on", {15'h0, port_intr}, 16'h0001);
		wr(`SSP_OFS_ICR, 16'h0000);
		rd(`SSP_OFS_RIS, v);
		chk("clear zero", v & 16'h0001, 16'h0001);
		wr(`SSP_OFS_ICR, 16'h0001);
		rd(`SSP_OFS_RIS, v);
		chk("clear one", v & 16'h0001, 16'h0000);
		chk("intr off", {15'h0, port_intr}, 16'h0000);
		for (i = 0; i < 8; i = i + 1)
		begin
			rd(`SSP_OFS_DATA, v);
			chk("rx word", v, {8'h00, 4'h3, i[3:0]});
		end
		rd(`SSP_OFS_DATA, v);
		chk("empty read", v, 16'h0000);
		$display("test loopback done");
		for (i = 0; i < 3; i = i + 1)
		begin
			wr(`SSP_OFS_OPC, 16'h0000);
			wr(`SSP_OFS_FFC, {10'h0, i[1:0], 4'h7});
			wr(`SSP_OFS_OPC, 16'h0003);
			wr(`SSP_OFS_DATA, 16'h00C6);
			poll("framed done", `SSP_OFS_STAT, 16'h0014, 16'h0004);
			rd(`SSP_OFS_DATA, v);
			chk("framed word", v, (i == 2) ? 16'h0000 : 16'h00C6);
		end
		$display("test framing done");
		// external peer at four and sixteen bits
		wr(`SSP_OFS_IMSC, 16'h0000);
		for (i = 0; i < 2; i = i + 1)
		begin
			peer_bits = i ? 5'h10 : 5'h04;
			m = i ? 16'hFFFF : 16'h000F;
			wr(`SSP_OFS_OPC, 16'h0000);
			wr(`SSP_OFS_FFC, i ? 16'h030F : 16'h0303);
			wr(`SSP_OFS_OPC, 16'h0002);
			wr(`SSP_OFS_DATA, 16'h5A3C);
			poll("peer done", `SSP_OFS_STAT, 16'h0014, 16'h0004);
			rd(`SSP_OFS_DATA, v);
			chk("received", v, peer_word & m);
			chk("sent", peer_rx & m, 16'h5A3C & m);
		end
		chk("select idle", {15'h0, fr}, 16'h0001);
		$display("test peer done");
		wr(`SSP_OFS_DMA, 16'h0003);
		rd(`SSP_OFS_DMA, v);
		chk("dma reg", v, 16'h0003);
		chk("tx request", {14'h0, tx_dma_req, rx_dma_req}, 16'h0002);
		wr(`SSP_OFS_DMA, 16'h0000);
		wr(`SSP_OFS_OPC, 16'h0006);
		rd(`SSP_OFS_OPC, v);
		chk("slave ctrl", v, 16'h0006);
		chk("slave clock", {15'h0, sck_oe}, 16'h0000);
		// slave word clocked in from outside, looped back internally
		wr(`SSP_OFS_OPC, 16'h0007);
		wr(`SSP_OFS_DATA, 16'h5A3C);
		repeat (4) @(posedge sys_clk);
		s_sel_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk("slave drive", {15'h0, tx_oe}, 16'h0001);
		for (i = 0; i < 16; i = i + 1)
		begin
			s_clk <= 1'b1;
			repeat (8) @(posedge sys_clk);
			s_clk <= 1'b0;
			repeat (8) @(posedge sys_clk);
		end
		s_sel_n <= 1'b1;
		poll("slave done", `SSP_OFS_STAT, 16'h0014, 16'h0004);
		rd(`SSP_OFS_DATA, v);
		chk("slave word", v, 16'h5A3C);
		$display("test dma and slave done");
		complete_run;
	end
endmodule // ssp_port_tb

bind ssp_port ssp_port_properties i_props (.sys_clk(sys_clk), .rst(rst), .reg_sel(reg_sel),
	.reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .port_intr(port_intr), .tx_dma_req(tx_dma_req),
	.rx_dma_req(rx_dma_req), .serial_clock_oe(serial_clock_oe), .frame_oe(frame_oe),
	.serial_transmit_oe(serial_transmit_oe));
